// file: bench/slm_checker.sv
// port checker for the label match receiver
`timescale 1ns/100ps
module slm_checker (
    input wire logic        mclk_i, rst_i, tbl_wr_i, tbl_rd_i,
    input wire logic [6:0]  tbl_addr_i, ram_wr_addr_o,
    input wire logic [15:0] tbl_wdata_i, tbl_rdata_o,
    input wire logic        ram_wr_valid_o, ram_wr_ready_i, fifo_pop_i, fifo_rvalid_o,
    input wire logic [31:0] ram_wr_data_o,
    input wire logic [1:0]  fifo_sel_i,
    input wire logic [3:0]  fifo_empty_o, fifo_full_o,
    input wire logic        general_interrupt_one_o, general_interrupt_two_o,
    input wire logic        general_interrupt_three_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_wr_then_rd;
        tbl_wr_i ##1 !tbl_wr_i ##1 (tbl_rd_i && !tbl_wr_i && tbl_addr_i == $past(tbl_addr_i, 2));
    endsequence
    sequence s_stalled;
        ram_wr_valid_o && !ram_wr_ready_i;
    endsequence
    property p_tbl_read; s_wr_then_rd |=> tbl_rdata_o == $past(tbl_wdata_i, 3); endproperty
    property p_rd_hold; !tbl_rd_i |=> $stable(tbl_rdata_o); endproperty
    property p_ram_hold;
        s_stalled |=> ram_wr_valid_o && $stable(ram_wr_addr_o) && $stable(ram_wr_data_o);
    endproperty
    property p_pop; fifo_pop_i && !fifo_empty_o[fifo_sel_i] |=> fifo_rvalid_o; endproperty
    property p_nopop; !(fifo_pop_i && !fifo_empty_o[fifo_sel_i]) |=> !fifo_rvalid_o; endproperty
    property p_flags; (fifo_empty_o & fifo_full_o) == 4'h0; endproperty
    property p_irq_pulse; general_interrupt_one_o |=> !general_interrupt_one_o; endproperty
    property p_irq_one;
        $onehot0({general_interrupt_one_o, general_interrupt_two_o, general_interrupt_three_o});
    endproperty
    property p_irq_store;
        general_interrupt_two_o || general_interrupt_three_o |-> ram_wr_valid_o;
    endproperty
    a_tbl_read: assert property (p_tbl_read) else $error("table read mismatch");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_ram_hold: assert property (p_ram_hold) else $error("store dropped");
    a_pop: assert property (p_pop) else $error("pop lost");
    a_nopop: assert property (p_nopop) else $error("stray pop data");
    a_flags: assert property (p_flags) else $error("empty and full");
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
    a_irq_one: assert property (p_irq_one) else $error("two irqs");
    a_irq_store: assert property (p_irq_store) else $error("irq without store");
endmodule : slm_checker
bind slm_top slm_checker u_chk (.*);

// file: bench/slm_line_model.sv
// line transceiver model feeding one receive lane
`timescale 1ns/100ps
module slm_line_model (
    input  wire logic        mclk_i,
    input  wire logic        bclk_i,
    input  wire logic        go_i,
    input  wire logic [31:0] word_i,
    input  wire logic [7:0]  half_i,
    output logic             one_o,
    output logic             zero_o,
    output logic             busy_o
);
    initial {one_o, zero_o, busy_o} = 3'h0;
    always begin
        @(posedge mclk_i);
        if (go_i) begin
            busy_o <= 1'b1;
            for (int i = 0; i < 32; i++) begin
                {one_o, zero_o} <= {word_i[i], !word_i[i]};
                repeat (half_i) @(posedge bclk_i);
                @(posedge mclk_i);
                {one_o, zero_o} <= 2'h0;
                repeat (half_i) @(posedge bclk_i);
                @(posedge mclk_i);
            end
            // gap ends the word
            repeat (4 * half_i) @(posedge bclk_i);
            @(posedge mclk_i);
            busy_o <= 1'b0;
        end
    end
endmodule : slm_line_model

// file: bench/tb_top.sv
// self-checking bench for the label match receiver
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
    $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
    logic mclk_i, rst_i, ce_i, bit_clk_zero_i, bit_clk_one_i, tbl_wr_i, tbl_rd_i;
    logic ram_wr_valid_o, ram_wr_ready_i, fifo_pop_i, fifo_rvalid_o;
    logic general_interrupt_one_o, general_interrupt_two_o, general_interrupt_three_o;
    logic [1:0]  pair_high_speed_i, fifo_sel_i;
    logic [3:0]  broadcast_en_i, line_one_i, line_zero_i, fifo_empty_o, fifo_full_o, go, busy;
    logic [6:0]  tbl_addr_i, ram_wr_addr_o, st_addr;
    logic [15:0] tbl_wdata_i, tbl_rdata_o;
    logic [31:0] ram_wr_data_o, fifo_rdata_o, word [4];
    int          miscompares, samples_checked, n_st, n_irq [3];
    slm_top dut (.*);
    for (genvar l = 0; l < 4; l++) begin : g_ln
        slm_line_model u_m (.mclk_i(mclk_i), .bclk_i(l < 2 ? bit_clk_zero_i : bit_clk_one_i),
            .go_i(go[l]), .word_i(word[l]), .half_i(pair_high_speed_i[l/2] ? 8'h05 : 8'h28),
            .one_o(line_one_i[l]), .zero_o(line_zero_i[l]), .busy_o(busy[l]));
    end
    initial begin mclk_i = 1'b0; forever #10 mclk_i = ~mclk_i; end
    initial begin bit_clk_zero_i = 1'b0; #7; forever #40 bit_clk_zero_i = ~bit_clk_zero_i; end
    initial begin bit_clk_one_i = 1'b0; #23; forever #40 bit_clk_one_i = ~bit_clk_one_i; end
    always @(posedge mclk_i) begin
        if (ram_wr_valid_o && ram_wr_ready_i) begin
            n_st++;
            st_addr = ram_wr_addr_o;
        end
        n_irq[0] += int'(general_interrupt_one_o);
        n_irq[1] += int'(general_interrupt_two_o);
        n_irq[2] += int'(general_interrupt_three_o);
    end
    task automatic tw(input logic [6:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        tbl_wr_i <= 1'b1;
        tbl_addr_i <= a;
        tbl_wdata_i <= d;
        @(posedge mclk_i);
        tbl_wr_i <= 1'b0;
    endtask : tw
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        @(posedge mclk_i);
        tbl_rd_i <= 1'b1;
        tbl_addr_i <= a;
        @(posedge mclk_i);
        tbl_rd_i <= 1'b0;
        #1 `CHK(tbl_rdata_o, e)
    endtask : rd
    task automatic send(input int l, input logic [31:0] w);
        @(posedge mclk_i);
        word[l] <= w;
        go[l] <= 1'b1;
        @(posedge mclk_i);
        go[l] <= 1'b0;
        @(posedge mclk_i);
        while (busy[l] === 1'b1) @(posedge mclk_i);
        // scan and store
        repeat (200) @(posedge mclk_i);
        #1;
    endtask : send
    task automatic t_table;
        for (int i = 0; i < 128; i++) tw(7'(i), 16'h00FF);
        tw(7'h03, 16'h5A35);
        tw(7'h0A, 16'h4A35);
        tw(7'h14, 16'h2141);
        tw(7'h1E, 16'hF400);
        rd(7'h1E, 16'hF400);
        rd(7'h7F, 16'h00FF);
    endtask : t_table
    task automatic t_lane0;
        @(posedge mclk_i);
        ram_wr_ready_i <= 1'b0;
        send(0, 32'hCAFE0235);
        `CHK(ram_wr_valid_o, 1'b1)
        `CHK(ram_wr_addr_o, 7'h0A)
        `CHK(ram_wr_data_o, 32'hCAFE0235)
        `CHK(n_irq[0], 1)
        `CHK(fifo_empty_o[0], 1'b0)
        @(posedge mclk_i);
        ram_wr_ready_i <= 1'b1;
        fifo_pop_i <= 1'b1;
        fifo_sel_i <= 2'h0;
        @(posedge mclk_i);
        fifo_pop_i <= 1'b0;
        #1 `CHK(fifo_rdata_o, 32'hCAFE0235)
        `CHK(n_st, 1)
    endtask : t_lane0
    task automatic t_lane1;
        send(1, 32'hCAFE0235);
        `CHK(st_addr, 7'h03)
        `CHK(fifo_empty_o[1], 1'b0)
        send(1, 32'h00000277);
        `CHK(n_st, 2)
        `CHK(n_irq[0], 2)
    endtask : t_lane1
    task automatic t_bcast_wild;
        @(posedge mclk_i);
        pair_high_speed_i <= 2'b01;
        broadcast_en_i <= 4'h4;
        send(2, 32'h00000041);
        `CHK(st_addr, 7'h14)
        `CHK(n_irq[1] + n_irq[2], 0)
        `CHK(fifo_empty_o[2], 1'b1)
        @(posedge mclk_i);
        pair_high_speed_i <= 2'b11;
        send(3, 32'h12345699);
        `CHK(st_addr, 7'h1E)
        `CHK(n_irq[2], 1)
    endtask : t_bcast_wild
    task automatic end_sim;
        if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    initial begin
        {rst_i, ce_i, ram_wr_ready_i, pair_high_speed_i} = 5'h1F;
        {tbl_wr_i, tbl_rd_i, fifo_pop_i, fifo_sel_i, broadcast_en_i, go} = '0;
        {tbl_addr_i, tbl_wdata_i} = '0;
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        #1 `CHK(fifo_empty_o, 4'hF)
        `CHK(fifo_full_o, 4'h0)
        t_table();
        t_lane0();
        t_lane1();
        t_bcast_wild();
        end_sim();
    end
    // slowest word near 11k cycles
    initial begin
        repeat (40000) @(posedge mclk_i);
        miscompares++;
        end_sim();
    end
endmodule : tb_top

// file: design/slm_rx_lane.sv
// one serial receive lane: bipolar line levels to a 32-bit word
`timescale 1ns/100ps
module slm_rx_lane (
    input  wire logic                  mclk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire logic                  tick_i,
    input  wire logic                  high_speed_i,
    input  wire logic                  line_one_i,
    input  wire logic                  line_zero_i,
    output logic [slm_pkg::WORD_W-1:0] word_o,
    output logic                       word_valid_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    slm_pkg::slm_lvl_t            prev_reg, prev_next, lvl;
    logic [slm_pkg::WORD_W-1:0]   shift_reg, shift_next;
    logic [slm_pkg::BITCNT_W-1:0] bit_reg, bit_next;
    logic [slm_pkg::GAP_W-1:0]    gap_reg, gap_next, gap_lim;
    logic                         valid_next;
    logic [slm_pkg::WORD_W-1:0]   word_next;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    always_comb begin
        lvl        = slm_pkg::slm_lvl_t'({line_zero_i, line_one_i});
        // bit clock ratio 10 or 80 sets the gap that ends a word
        gap_lim    = high_speed_i ? slm_pkg::HS_GAP : slm_pkg::LS_GAP;
        prev_next  = prev_reg;
        shift_next = shift_reg;
        bit_next   = bit_reg;
        gap_next   = gap_reg;
        valid_next = 1'b0;
        word_next  = word_o;
        if (tick_i) begin
            prev_next = lvl;
            case (lvl)
                slm_pkg::SLM_LVL_NULL: begin
                    // long null means the word was cut short; resync
                    if (gap_reg >= gap_lim) begin
                        bit_next = '0;
                    end else begin
                        gap_next = gap_reg + 1'b1;
                    end
                end
                slm_pkg::SLM_LVL_BAD: begin
                    bit_next = '0;
                    gap_next = '0;
                end
                default: begin
                    gap_next = '0;
                    // edge-timed sampling tolerates +-5% rate drift
                    if (prev_reg == slm_pkg::SLM_LVL_NULL) begin
                        shift_next = {lvl == slm_pkg::SLM_LVL_ONE,
                                      shift_reg[slm_pkg::WORD_W-1:1]};
                        bit_next   = bit_reg + 1'b1;
                        if (bit_reg == slm_pkg::LAST_BIT) begin
                            valid_next = 1'b1;
                            word_next  = shift_next;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_reg <= slm_pkg::SLM_LVL_NULL;
            shift_reg <= '0;
            bit_reg <= '0;
            gap_reg <= '0;
            word_valid_o <= 1'b0;
            word_o <= '0;
        end else if (ce_i) begin
            prev_reg <= prev_next;
            shift_reg <= shift_next;
            bit_reg <= bit_next;
            gap_reg <= gap_next;
            word_valid_o <= valid_next;
            word_o <= word_next;
        end
    end

endmodule : slm_rx_lane

// file: design/slm_top.sv
// four lane receiver with label match table, store path and receive fifos
// ------------------------------------------------------------
// Operation
// - four identical independent receive lanes
// - one speed bit per lane pair
// - decode within plus/minus five percent rate
// - bit clock is 10x or 80x rate
// - clock zero times lanes 0-1, one 2-3
// - shift serial stream into 32-bit word
// - 128 by 16 host-written match table
// - store word at entry address minus 0x200
// - label bits 0-7, zero matches any
// - source/destination bits 8-9, bit 10 wildcard
// - broadcast enable makes pair 00 match
// - entry bits 12-13 equal lane number
// - match needs all three comparisons true
// - bit 11 also pushes word into fifo
// - bits 14-15 pick interrupt, 00 none
// - each fifo 32 words by 32 bits
// - route zero disables the interrupt
// ------------------------------------------------------------
`timescale 1ns/100ps
module slm_top #(
    parameter int FIFO_DEPTH = slm_pkg::FIFO_DEPTH
) (
    input  wire logic                          mclk_i,
    input  wire logic                          rst_i,
    input  wire logic                          ce_i,
    input  wire logic                          bit_clk_zero_i,
    input  wire logic                          bit_clk_one_i,
    input  wire logic [1:0]                    pair_high_speed_i,
    input  wire logic [slm_pkg::NUM_LANES-1:0] broadcast_en_i,
    input  wire logic [slm_pkg::NUM_LANES-1:0] line_one_i,
    input  wire logic [slm_pkg::NUM_LANES-1:0] line_zero_i,
    input  wire logic                          tbl_wr_i,
    input  wire logic                          tbl_rd_i,
    input  wire logic [slm_pkg::TBL_AW-1:0]    tbl_addr_i,
    input  wire logic [slm_pkg::TBL_W-1:0]     tbl_wdata_i,
    output logic [slm_pkg::TBL_W-1:0]          tbl_rdata_o,
    output logic                               ram_wr_valid_o,
    input  wire logic                          ram_wr_ready_i,
    output logic [slm_pkg::TBL_AW-1:0]         ram_wr_addr_o,
    output logic [slm_pkg::WORD_W-1:0]         ram_wr_data_o,
    input  wire logic                          fifo_pop_i,
    input  wire logic [slm_pkg::LANE_W-1:0]    fifo_sel_i,
    output logic [slm_pkg::WORD_W-1:0]         fifo_rdata_o,
    output logic                               fifo_rvalid_o,
    output logic [slm_pkg::NUM_LANES-1:0]      fifo_empty_o,
    output logic [slm_pkg::NUM_LANES-1:0]      fifo_full_o,
    output logic                               general_interrupt_one_o,
    output logic                               general_interrupt_two_o,
    output logic                               general_interrupt_three_o
);

    localparam int FAW = $clog2(FIFO_DEPTH);

    // ------------------------------------------------------------
    // bit clock edges and lanes
    // ------------------------------------------------------------
    logic                          clk0_prev_reg, clk1_prev_reg;
    logic [1:0]                    pair_tick;
    logic [slm_pkg::WORD_W-1:0]    lane_word  [slm_pkg::NUM_LANES];
    logic [slm_pkg::NUM_LANES-1:0] lane_valid;

    // clock zero serves lanes 0 and 1, clock one lanes 2 and 3
    assign pair_tick[0] = bit_clk_zero_i & ~clk0_prev_reg;
    assign pair_tick[1] = bit_clk_one_i & ~clk1_prev_reg;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            clk0_prev_reg <= 1'b0;
            clk1_prev_reg <= 1'b0;
        end else if (ce_i) begin
            clk0_prev_reg <= bit_clk_zero_i;
            clk1_prev_reg <= bit_clk_one_i;
        end
    end

    for (genvar g = 0; g < slm_pkg::NUM_LANES; g++) begin : g_lane
        slm_rx_lane u_lane (
            .mclk_i       (mclk_i),
            .rst_i        (rst_i),
            .ce_i         (ce_i),
            .tick_i       (pair_tick[g/2]),
            .high_speed_i (pair_high_speed_i[g/2]),
            .line_one_i   (line_one_i[g]),
            .line_zero_i  (line_zero_i[g]),
            .word_o       (lane_word[g]),
            .word_valid_o (lane_valid[g])
        );
    end

    // ------------------------------------------------------------
    // match table
    // ------------------------------------------------------------
    logic [slm_pkg::TBL_W-1:0] tbl_mem [slm_pkg::TBL_DEPTH];

    always_ff @(posedge mclk_i) begin
        if (ce_i && tbl_wr_i) begin
            tbl_mem[tbl_addr_i] <= tbl_wdata_i;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tbl_rdata_o <= '0;
        end else if (ce_i && tbl_rd_i) begin
            tbl_rdata_o <= tbl_mem[tbl_addr_i];
        end
    end

    // ------------------------------------------------------------
    // pending words and scan engine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SLM_IDLE, SLM_SCAN, SLM_STORE} slm_state_t;

    slm_state_t                    st_reg, st_next;
    logic [slm_pkg::NUM_LANES-1:0] pend_reg, pend_next;
    logic [slm_pkg::WORD_W-1:0]    pword_reg [slm_pkg::NUM_LANES];
    logic [slm_pkg::WORD_W-1:0]    pword_next [slm_pkg::NUM_LANES];
    logic [slm_pkg::LANE_W-1:0]    lane_reg, lane_next;
    logic [slm_pkg::WORD_W-1:0]    cword_reg, cword_next;
    logic [slm_pkg::TBL_AW-1:0]    idx_reg, idx_next;
    logic [slm_pkg::TBL_W-1:0]     hit_reg, hit_next, ent;
    logic                          lbl_ok, sd_ok, ch_ok, is_match;
    logic                          buf_push, buf_in_ready;
    logic [slm_pkg::HOST_AW-1:0]   entry_addr, ram_addr_full;
    logic [slm_pkg::NUM_LANES-1:0] fifo_push;
    logic [3:1]                    irq_next;
    logic                          taken;

    always_comb begin
        ent    = tbl_mem[idx_reg];
        // zero label in the entry is a wildcard
        lbl_ok = (ent[slm_pkg::LABEL_MSB:slm_pkg::LABEL_LSB] == slm_pkg::LABEL_ANY)
               | (ent[slm_pkg::LABEL_MSB:slm_pkg::LABEL_LSB]
                  == cword_reg[slm_pkg::LABEL_MSB:slm_pkg::LABEL_LSB]);
        sd_ok  = ent[slm_pkg::SD_ANY_BIT]
               | (ent[slm_pkg::SD_MSB:slm_pkg::SD_LSB]
                  == cword_reg[slm_pkg::SD_MSB:slm_pkg::SD_LSB])
               | (broadcast_en_i[lane_reg]
                  & (cword_reg[slm_pkg::SD_MSB:slm_pkg::SD_LSB] == slm_pkg::SD_BCAST));
        ch_ok  = ent[slm_pkg::CH_MSB:slm_pkg::CH_LSB] == lane_reg;
        is_match = lbl_ok & sd_ok & ch_ok;
    end

    always_comb begin
        st_next    = st_reg;
        pend_next  = pend_reg;
        pword_next = pword_reg;
        lane_next  = lane_reg;
        cword_next = cword_reg;
        idx_next   = idx_reg;
        hit_next   = hit_reg;
        buf_push   = 1'b0;
        fifo_push  = '0;
        irq_next   = '0;
        taken      = 1'b0;
        case (st_reg)
            SLM_IDLE: begin
                // fixed priority, lowest lane first
                for (int i = slm_pkg::NUM_LANES - 1; i >= 0; i--) begin
                    if (pend_reg[i]) begin
                        lane_next  = slm_pkg::LANE_W'(i);
                        cword_next = pword_reg[i];
                        taken      = 1'b1;
                    end
                end
                if (taken) begin
                    pend_next[lane_next] = 1'b0;
                    idx_next             = '0;
                    st_next              = SLM_SCAN;
                end
            end
            SLM_SCAN: begin
                if (is_match) begin
                    hit_next = ent; // first matching entry wins
                    st_next  = SLM_STORE;
                end else if (idx_reg == slm_pkg::TBL_AW'(slm_pkg::TBL_DEPTH - 1)) begin
                    st_next = SLM_IDLE;
                end else begin
                    idx_next = idx_reg + 1'b1;
                end
            end
            SLM_STORE: begin
                // stall while the buffer is full
                if (buf_in_ready) begin
                    buf_push = 1'b1;
                    fifo_push[lane_reg] = hit_reg[slm_pkg::FIFO_EN_BIT];
                    case (hit_reg[slm_pkg::IRQ_MSB:slm_pkg::IRQ_LSB])
                        slm_pkg::GEN_IRQ_ONE:   irq_next[1] = 1'b1;
                        slm_pkg::GEN_IRQ_TWO:   irq_next[2] = 1'b1;
                        slm_pkg::GEN_IRQ_THREE: irq_next[3] = 1'b1;
                        default:                irq_next    = '0;
                    endcase
                    st_next = SLM_IDLE;
                end
            end
            default: st_next = SLM_IDLE;
        endcase
        // new word wins over a same-cycle take
        for (int i = 0; i < slm_pkg::NUM_LANES; i++) begin
            if (lane_valid[i]) begin
                pend_next[i]  = 1'b1;
                pword_next[i] = lane_word[i];
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= SLM_IDLE;
            pend_reg <= '0;
            pword_reg <= '{default: '0};
            lane_reg <= '0;
            cword_reg <= '0;
            idx_reg <= '0;
            hit_reg <= '0;
            general_interrupt_one_o <= 1'b0;
            general_interrupt_two_o <= 1'b0;
            general_interrupt_three_o <= 1'b0;
        end else if (ce_i) begin
            st_reg <= st_next;
            pend_reg <= pend_next;
            pword_reg <= pword_next;
            lane_reg <= lane_next;
            cword_reg <= cword_next;
            idx_reg <= idx_next;
            hit_reg <= hit_next;
            general_interrupt_one_o <= irq_next[1];
            general_interrupt_two_o <= irq_next[2];
            general_interrupt_three_o <= irq_next[3];
        end
    end

    // ------------------------------------------------------------
    // two-entry store buffer toward receive ram
    // ------------------------------------------------------------
    logic                       skid_v_reg, skid_v_next, out_v_next;
    logic [slm_pkg::TBL_AW-1:0] skid_a_reg, skid_a_next, out_a_next;
    logic [slm_pkg::WORD_W-1:0] skid_d_reg, skid_d_next, out_d_next;

    assign entry_addr    = slm_pkg::TBL_BASE + slm_pkg::HOST_AW'(idx_reg);
    assign ram_addr_full = entry_addr - slm_pkg::TBL_BASE;
    assign buf_in_ready  = ~skid_v_reg;

    always_comb begin
        out_v_next  = ram_wr_valid_o;
        out_a_next  = ram_wr_addr_o;
        out_d_next  = ram_wr_data_o;
        skid_v_next = skid_v_reg;
        skid_a_next = skid_a_reg;
        skid_d_next = skid_d_reg;
        if (!ram_wr_valid_o || ram_wr_ready_i) begin
            if (skid_v_reg) begin
                out_v_next  = 1'b1;
                out_a_next  = skid_a_reg;
                out_d_next  = skid_d_reg;
                skid_v_next = buf_push;
                skid_a_next = ram_addr_full[slm_pkg::TBL_AW-1:0];
                skid_d_next = cword_reg;
            end else begin
                out_v_next = buf_push;
                out_a_next = ram_addr_full[slm_pkg::TBL_AW-1:0];
                out_d_next = cword_reg;
            end
        end else if (buf_push) begin
            skid_v_next = 1'b1;
            skid_a_next = ram_addr_full[slm_pkg::TBL_AW-1:0];
            skid_d_next = cword_reg;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ram_wr_valid_o <= 1'b0;
            ram_wr_addr_o <= '0;
            ram_wr_data_o <= '0;
            skid_v_reg <= 1'b0;
            skid_a_reg <= '0;
            skid_d_reg <= '0;
        end else if (ce_i) begin
            ram_wr_valid_o <= out_v_next;
            ram_wr_addr_o <= out_a_next;
            ram_wr_data_o <= out_d_next;
            skid_v_reg <= skid_v_next;
            skid_a_reg <= skid_a_next;
            skid_d_reg <= skid_d_next;
        end
    end

    // ------------------------------------------------------------
    // receive fifos
    // ------------------------------------------------------------
    logic [slm_pkg::WORD_W-1:0] fifo_mem [slm_pkg::NUM_LANES][FIFO_DEPTH];
    logic [FAW-1:0]             wp_reg [slm_pkg::NUM_LANES];
    logic [FAW-1:0]             wp_next [slm_pkg::NUM_LANES];
    logic [FAW-1:0]             rp_reg [slm_pkg::NUM_LANES];
    logic [FAW-1:0]             rp_next [slm_pkg::NUM_LANES];
    logic [FAW:0]               cnt_reg [slm_pkg::NUM_LANES];
    logic [FAW:0]               cnt_next [slm_pkg::NUM_LANES];
    logic [slm_pkg::NUM_LANES-1:0] do_push, do_pop, empty_next, full_next;
    logic                       rvalid_next;
    logic [slm_pkg::WORD_W-1:0] rdata_next;

    always_comb begin
        rvalid_next = 1'b0;
        rdata_next  = fifo_rdata_o;
        for (int i = 0; i < slm_pkg::NUM_LANES; i++) begin
            // full fifo drops the word; ram copy still written
            do_push[i]    = fifo_push[i] & ~fifo_full_o[i];
            do_pop[i]     = fifo_pop_i & (fifo_sel_i == slm_pkg::LANE_W'(i))
                          & ~fifo_empty_o[i];
            wp_next[i]    = do_push[i] ? FAW'(wp_reg[i] + 1'b1) : wp_reg[i];
            rp_next[i]    = do_pop[i] ? FAW'(rp_reg[i] + 1'b1) : rp_reg[i];
            cnt_next[i]   = cnt_reg[i] + (FAW+1)'(do_push[i]) - (FAW+1)'(do_pop[i]);
            empty_next[i] = cnt_next[i] == '0;
            full_next[i]  = cnt_next[i] == (FAW+1)'(FIFO_DEPTH);
            if (do_pop[i]) begin
                rvalid_next = 1'b1;
                rdata_next  = fifo_mem[i][rp_reg[i]];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < slm_pkg::NUM_LANES; i++) begin
            if (ce_i && do_push[i]) begin
                fifo_mem[i][wp_reg[i]] <= cword_reg;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wp_reg <= '{default: '0};
            rp_reg <= '{default: '0};
            cnt_reg <= '{default: '0};
            fifo_empty_o <= '1;
            fifo_full_o <= '0;
            fifo_rvalid_o <= 1'b0;
            fifo_rdata_o <= '0;
        end else if (ce_i) begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
            fifo_empty_o <= empty_next;
            fifo_full_o <= full_next;
            fifo_rvalid_o <= rvalid_next;
            fifo_rdata_o <= rdata_next;
        end
    end

endmodule : slm_top

// file: pkg/slm_pkg.sv
// constants shared by the serial label match receiver
package slm_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_LANES   = 4;
    localparam int WORD_W      = 32;
    localparam int TBL_DEPTH   = 128;
    localparam int TBL_W       = 16;
    localparam int TBL_AW      = 7;
    localparam int HOST_AW     = 11;
    localparam int FIFO_DEPTH  = 32;
    localparam int FIFO_AW     = 5;
    localparam int LANE_W      = 2;

    // ------------------------------------------------------------
    // match table entry layout
    // ------------------------------------------------------------
    localparam int LABEL_LSB   = 0;
    localparam int LABEL_MSB   = 7;
    localparam int SD_LSB      = 8;
    localparam int SD_MSB      = 9;
    localparam int SD_ANY_BIT  = 10;
    localparam int FIFO_EN_BIT = 11;
    localparam int CH_LSB      = 12;
    localparam int CH_MSB      = 13;
    localparam int IRQ_LSB     = 14;
    localparam int IRQ_MSB     = 15;

    // host address of entry zero
    localparam logic [HOST_AW-1:0] TBL_BASE = 11'h200;

    localparam logic [7:0] LABEL_ANY  = 8'h00;
    localparam logic [1:0] SD_BCAST   = 2'h0;

    // interrupt routing codes
    localparam logic [1:0] NULL_INTERRUPT_ROUTE = 2'h0;
    localparam logic [1:0] GEN_IRQ_ONE          = 2'h1;
    localparam logic [1:0] GEN_IRQ_TWO          = 2'h2;
    localparam logic [1:0] GEN_IRQ_THREE        = 2'h3;

    // ------------------------------------------------------------
    // bit timing: bit clock ticks per data bit
    // ------------------------------------------------------------
    localparam int HS_RATIO  = 10;
    localparam int LS_RATIO  = 80;
    localparam int GAP_NUM   = 3;
    localparam int GAP_DEN   = 2;
    localparam int GAP_W     = 8;
    localparam logic [GAP_W-1:0] HS_GAP = GAP_W'(HS_RATIO * GAP_NUM / GAP_DEN);
    localparam logic [GAP_W-1:0] LS_GAP = GAP_W'(LS_RATIO * GAP_NUM / GAP_DEN);
    localparam int BITCNT_W  = 5;
    localparam logic [BITCNT_W-1:0] LAST_BIT = 5'h1F;

    typedef enum logic [1:0] {
        SLM_LVL_NULL,
        SLM_LVL_ONE,
        SLM_LVL_ZERO,
        SLM_LVL_BAD
    } slm_lvl_t;

endpackage : slm_pkg
